// ==== logic/abfp_defines.svh ====
// constants for the asynchronous byte fifo port
// assumes nothing beyond a single 40 MHz core clock
`ifndef ABFP_DEFINES_SVH
`define ABFP_DEFINES_SVH
`define ABFP_DATA_W 8
`define ABFP_CLK_NS 25
// strobe low and high phase the far end holds, in ns
`define ABFP_STROBE_NS 100
`define ABFP_STROBE_CYC ((`ABFP_STROBE_NS + `ABFP_CLK_NS - 1) / `ABFP_CLK_NS)
// wake / send-now low pulse width, in ns
`define ABFP_WAKE_NS 100
`define ABFP_WAKE_CYC ((`ABFP_WAKE_NS + `ABFP_CLK_NS - 1) / `ABFP_CLK_NS)
`endif

// ==== logic/abfp_pkg.sv ====
// types shared by both ends of the byte fifo port
// assumes abfp_defines.svh is on the include path
package abfp_pkg;
    typedef logic [7:0] abfp_byte_t;
    typedef enum logic [2:0] {
        ABFP_IDLE = 3'b000,
        ABFP_RD_LOW = 3'b001,
        ABFP_RD_HIGH = 3'b010,
        ABFP_WR_SETUP = 3'b011,
        ABFP_WR_LOW = 3'b100,
        ABFP_WR_HIGH = 3'b101,
        ABFP_WAKE_LOW = 3'b110
    } abfp_host_state_t;
endpackage : abfp_pkg

// ==== logic/abfp_if.sv ====
// pin bundle between the fifo port device and its external controller
// the testbench resolves the data wire from the two enables
`timescale 1ns/10ps
interface abfp_if;
    logic [7:0] dev_data_out;
    logic dev_data_oe;
    logic [7:0] host_data_out;
    logic host_data_oe;
    logic [7:0] data_in;
    logic rd_n;
    logic wr_n;
    logic send_now_wake_n;
    logic rx_data_waiting_n_out;
    logic rx_data_waiting_n_oe;
    logic tx_room_available_n_out;
    logic tx_room_available_n_oe;
    logic rx_data_waiting_n;
    logic tx_room_available_n;
    modport device (
        output dev_data_out, dev_data_oe,
        output rx_data_waiting_n_out, rx_data_waiting_n_oe,
        output tx_room_available_n_out, tx_room_available_n_oe,
        input data_in, rd_n, wr_n, send_now_wake_n
    );
    modport host (
        output host_data_out, host_data_oe, rd_n, wr_n, send_now_wake_n,
        input data_in, rx_data_waiting_n, tx_room_available_n
    );
endinterface : abfp_if

// ==== logic/abfp_device.sv ====
// device end of the asynchronous byte fifo port, one channel
// strobes arrive from pins and are synchronised to mclk here
// Operation
// - port active only when fifo mode selected
// - data pins driven only while read low
// - waiting flag low while rx byte present
// - flag high after read, low if more
// - flags undriven during reset
// - room flag low when tx fifo accepts
// - host writes by strobing write high, low
// - write falling edge captures byte
// - read falling edge presents head byte
// - read rising edge advances rx fifo
// - wake pulse in suspend requests resume
// - send-now pulse while active raises send_now_pulse
// - host holds wake input high normally
`timescale 1ns/10ps
`include "abfp_defines.svh"
module abfp_device
    import abfp_pkg::*;
#(
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic mclk,
    input wire logic rst,
    abfp_if.device pins,
    input wire logic fifo_mode_en,
    input wire logic usb_active_power_n,
    input wire logic remote_wake_en,
    input wire logic rx_push,
    input wire abfp_byte_t rx_push_data,
    output logic rx_full,
    input wire logic tx_pop,
    output abfp_byte_t tx_pop_data,
    output logic tx_empty,
    output logic send_now_pulse,
    output logic resume_req_pulse
);
    localparam int NSTB = 3;
    // bit of each strobe in the synchroniser bank
    localparam int STB_RD = 0;
    localparam int STB_WR = 1;
    localparam int STB_SW = 2;

    abfp_byte_t rx_mem_ff [DEPTH];
    abfp_byte_t tx_mem_ff [DEPTH];
    logic [AW:0] rx_wp_ff, nxt_rx_wp, rx_rp_ff, nxt_rx_rp;
    logic [AW:0] tx_wp_ff, nxt_tx_wp, tx_rp_ff, nxt_tx_rp;
    logic [NSTB-1:0] stb_raw;
    wire logic [NSTB-1:0] stb_lvl, stb_fall, stb_rise;
    abfp_byte_t din1_ff, nxt_din1, din2_ff, nxt_din2;
    logic rd_busy_ff, nxt_rd_busy;
    abfp_byte_t dout_ff, nxt_dout;
    logic rd_fall, rd_rise, wr_fall, sw_fall;
    logic rx_empty, tx_full;
    logic rx_load, rx_take, tx_load, tx_take;

    assign stb_raw = {pins.send_now_wake_n, pins.wr_n, pins.rd_n};

    // one two-stage synchroniser and edge detector per strobe; all
    // reset to the idle high level so no false edge follows reset
    for (genvar g = 0; g < NSTB; g++) begin : g_stb
        logic s1_ff, nxt_s1, s2_ff, nxt_s2, pv_ff, nxt_pv;
        always_comb begin
            nxt_s1 = stb_raw[g];
            nxt_s2 = s1_ff;
            nxt_pv = s2_ff;
        end
        // first stage feeds only the second
        always_ff @(posedge mclk) begin
            if (rst) begin
                s1_ff <= 1'b1;
                s2_ff <= 1'b1;
                pv_ff <= 1'b1;
            end else begin
                s1_ff <= nxt_s1;
                s2_ff <= nxt_s2;
                pv_ff <= nxt_pv;
            end
        end
        assign stb_lvl[g] = s2_ff;
        assign stb_fall[g] = fifo_mode_en && pv_ff && !s2_ff;
        assign stb_rise[g] = fifo_mode_en && !pv_ff && s2_ff;
    end

    assign rd_fall = stb_fall[STB_RD];
    assign rd_rise = stb_rise[STB_RD];
    assign wr_fall = stb_fall[STB_WR];
    assign sw_fall = stb_fall[STB_SW];

    // data pins cross like the strobes; the byte stands on the pins
    // well before the write strobe falls, so both arrive aligned
    // limitation: a host that changes data with the strobe loses it
    always_comb begin
        nxt_din1 = pins.data_in;
        nxt_din2 = din1_ff;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            din1_ff <= 8'h00;
            din2_ff <= 8'h00;
        end else begin
            din1_ff <= nxt_din1;
            din2_ff <= nxt_din2;
        end
    end

    assign rx_empty = (rx_wp_ff == rx_rp_ff);
    assign rx_full = (rx_wp_ff[AW] != rx_rp_ff[AW]) &&
                     (rx_wp_ff[AW-1:0] == rx_rp_ff[AW-1:0]);
    assign tx_empty = (tx_wp_ff == tx_rp_ff);
    assign tx_full = (tx_wp_ff[AW] != tx_rp_ff[AW]) &&
                     (tx_wp_ff[AW-1:0] == tx_rp_ff[AW-1:0]);
    assign tx_pop_data = tx_mem_ff[tx_rp_ff[AW-1:0]];

    // a read on an empty fifo is ignored, and its release with it
    assign rx_load = rx_push && !rx_full;
    assign rx_take = rd_rise && rd_busy_ff;
    // a write into a full fifo is dropped; the room flag forbids it
    assign tx_load = wr_fall && !tx_full;
    assign tx_take = tx_pop && !tx_empty;

    // receive side: pointers, presented byte, read in progress
    always_comb begin
        nxt_rx_wp = rx_wp_ff;
        nxt_rx_rp = rx_rp_ff;
        nxt_rd_busy = rd_busy_ff;
        nxt_dout = dout_ff;
        if (rx_load) begin
            nxt_rx_wp = rx_wp_ff + 1'b1;
        end
        if (rd_fall && !rx_empty) begin
            nxt_dout = rx_mem_ff[rx_rp_ff[AW-1:0]];
            nxt_rd_busy = 1'b1;
        end
        if (rx_take) begin
            nxt_rx_rp = rx_rp_ff + 1'b1;
            nxt_rd_busy = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rx_wp_ff <= '0;
            rx_rp_ff <= '0;
            rd_busy_ff <= 1'b0;
            dout_ff <= 8'h00;
        end else begin
            rx_wp_ff <= nxt_rx_wp;
            rx_rp_ff <= nxt_rx_rp;
            rd_busy_ff <= nxt_rd_busy;
            dout_ff <= nxt_dout;
        end
    end

    // transmit side: pointers only, the core drains the head
    always_comb begin
        nxt_tx_wp = tx_wp_ff;
        nxt_tx_rp = tx_rp_ff;
        if (tx_load) begin
            nxt_tx_wp = tx_wp_ff + 1'b1;
        end
        if (tx_take) begin
            nxt_tx_rp = tx_rp_ff + 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            tx_wp_ff <= '0;
            tx_rp_ff <= '0;
        end else begin
            tx_wp_ff <= nxt_tx_wp;
            tx_rp_ff <= nxt_tx_rp;
        end
    end

    // memories carry no reset; pointers guard every read
    always_ff @(posedge mclk) begin
        if (rx_load) begin
            rx_mem_ff[rx_wp_ff[AW-1:0]] <= rx_push_data;
        end
        if (tx_load) begin
            tx_mem_ff[tx_wp_ff[AW-1:0]] <= din2_ff;
        end
    end

    // flags: waiting stays high through a read and after its release,
    // until the pointer has moved; room low while not full
    assign pins.rx_data_waiting_n_out = !(fifo_mode_en && !rx_empty &&
        stb_lvl[STB_RD] && !rd_busy_ff);
    assign pins.tx_room_available_n_out = !(fifo_mode_en && !tx_full);
    assign pins.rx_data_waiting_n_oe = !rst && fifo_mode_en;
    assign pins.tx_room_available_n_oe = !rst && fifo_mode_en;
    // raw pin keeps bus turnaround prompt; data is from a flip-flop
    assign pins.dev_data_oe = !rst && fifo_mode_en && !pins.rd_n;
    assign pins.dev_data_out = dout_ff;

    // suspend level at the detected edge picks resume or send-now
    assign send_now_pulse = sw_fall && !usb_active_power_n;
    assign resume_req_pulse = sw_fall && usb_active_power_n &&
                              remote_wake_en;
endmodule : abfp_device

// ==== logic/abfp_host.sv ====
// external controller end: issues reads, writes and wake pulses
// assumes the device flags may float high during device reset
`timescale 1ns/10ps
`include "abfp_defines.svh"
module abfp_host
    import abfp_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    abfp_if.host pins,
    input wire logic rd_req,
    input wire logic wr_req,
    input wire abfp_byte_t wr_data,
    input wire logic wake_req,
    output logic busy,
    output logic rd_valid,
    output abfp_byte_t rd_data
);
    abfp_host_state_t st_ff, nxt_st;
    logic [7:0] cnt_ff, nxt_cnt;
    abfp_byte_t wd_ff, nxt_wd, rdat_ff, nxt_rdat;
    logic rv_ff, nxt_rv;
    logic [1:0] s1_ff, s2_ff;
    abfp_byte_t d1_ff, d2_ff;

    always_ff @(posedge mclk) begin
        if (rst) begin
            s1_ff <= 2'h3;
            s2_ff <= 2'h3;
            d1_ff <= 8'h00;
            d2_ff <= 8'h00;
        end else begin
            s1_ff <= {pins.tx_room_available_n, pins.rx_data_waiting_n};
            s2_ff <= s1_ff;
            d1_ff <= pins.data_in;
            d2_ff <= d1_ff;
        end
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_cnt = cnt_ff;
        nxt_wd = wd_ff;
        nxt_rdat = rdat_ff;
        nxt_rv = 1'b0;
        case (st_ff)
            ABFP_IDLE: begin
                nxt_cnt = 8'(`ABFP_STROBE_CYC);
                if (wake_req) begin
                    nxt_cnt = 8'(`ABFP_WAKE_CYC);
                    nxt_st = ABFP_WAKE_LOW;
                end else if (rd_req && !s2_ff[0]) begin
                    nxt_st = ABFP_RD_LOW;
                end else if (wr_req && !s2_ff[1]) begin
                    nxt_wd = wr_data;
                    nxt_st = ABFP_WR_SETUP;
                end
            end
            ABFP_RD_LOW: begin
                nxt_cnt = cnt_ff - 8'h01;
                if (cnt_ff == 8'h01) begin
                    nxt_cnt = 8'(`ABFP_STROBE_CYC);
                    nxt_st = ABFP_RD_HIGH;
                end
            end
            ABFP_WR_SETUP: begin
                nxt_cnt = cnt_ff - 8'h01;
                if (cnt_ff == 8'h01) begin
                    nxt_cnt = 8'(`ABFP_STROBE_CYC);
                    nxt_st = ABFP_WR_LOW;
                end
            end
            ABFP_WR_LOW: begin
                nxt_cnt = cnt_ff - 8'h01;
                if (cnt_ff == 8'h01) begin
                    nxt_cnt = 8'(`ABFP_STROBE_CYC);
                    nxt_st = ABFP_WR_HIGH;
                end
            end
            ABFP_RD_HIGH, ABFP_WR_HIGH, ABFP_WAKE_LOW: begin
                // recovery lets the flags settle before the next look
                nxt_cnt = cnt_ff - 8'h01;
                // the read byte reaches d2_ff on the first edge after release
                if (st_ff == ABFP_RD_HIGH &&
                    cnt_ff == 8'(`ABFP_STROBE_CYC - 1)) begin
                    nxt_rdat = d2_ff;
                    nxt_rv = 1'b1;
                end
                if (cnt_ff == 8'h01) begin
                    nxt_cnt = (st_ff == ABFP_WAKE_LOW) ?
                              8'(`ABFP_STROBE_CYC) : 8'h00;
                    nxt_st = (st_ff == ABFP_WAKE_LOW) ?
                             ABFP_WR_HIGH : ABFP_IDLE;
                end
            end
            default: begin
                nxt_st = ABFP_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st_ff <= ABFP_IDLE;
            cnt_ff <= 8'h00;
            wd_ff <= 8'h00;
            rdat_ff <= 8'h00;
            rv_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
            wd_ff <= nxt_wd;
            rdat_ff <= nxt_rdat;
            rv_ff <= nxt_rv;
        end
    end

    assign pins.rd_n = (st_ff != ABFP_RD_LOW);
    assign pins.wr_n = (st_ff != ABFP_WR_LOW);
    assign pins.send_now_wake_n = (st_ff != ABFP_WAKE_LOW);
    assign pins.host_data_out = wd_ff;
    // drive data through write setup, low and hold phases
    assign pins.host_data_oe = (st_ff == ABFP_WR_SETUP) ||
        (st_ff == ABFP_WR_LOW) || (st_ff == ABFP_WR_HIGH);
    assign busy = (st_ff != ABFP_IDLE);
    assign rd_valid = rv_ff;
    assign rd_data = rdat_ff;
endmodule : abfp_host

// ==== verif/abfp_assertions.sv ====
// pin checker for the byte fifo port, one mclk domain
// assumes it watches the interface joining device and host ends
`timescale 1ns/10ps
module abfp_assertions (
    input wire logic mclk,
    input wire logic rst,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic send_now_wake_n,
    input wire logic dev_data_oe,
    input wire logic host_data_oe,
    input wire logic rx_data_waiting_n,
    input wire logic tx_room_available_n,
    input wire logic rx_data_waiting_n_oe,
    input wire logic tx_room_available_n_oe
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    property p_no_clash;
        !(dev_data_oe && host_data_oe);
    endproperty
    a_no_clash: assert property (p_no_clash)
        else $error("data bus driven by both ends");
    property p_oe_rd;
        $rose(dev_data_oe) |-> !rd_n;
    endproperty
    a_oe_rd: assert property (p_oe_rd)
        else $error("data driven without read low");
    property p_oe_drop;
        $rose(rd_n) |-> ##[1:4] !dev_data_oe;
    endproperty
    a_oe_drop: assert property (p_oe_drop)
        else $error("data still driven after read");
    // the last reset cycle must show every device output released
    property p_rst_quiet;
        $fell(rst) |-> !$past(rx_data_waiting_n_oe) &&
            !$past(tx_room_available_n_oe) && !$past(dev_data_oe);
    endproperty
    a_rst_quiet: assert property (p_rst_quiet)
        else $error("pins driven out of reset");
    property p_rd_flag;
        $fell(rd_n) |-> !rx_data_waiting_n;
    endproperty
    a_rd_flag: assert property (p_rd_flag)
        else $error("read started with no byte waiting");
    property p_flag_up;
        $fell(rd_n) |-> ##[1:4] rx_data_waiting_n;
    endproperty
    a_flag_up: assert property (p_flag_up)
        else $error("waiting flag not raised by read");
    property p_wr_flag;
        $fell(wr_n) |-> !tx_room_available_n;
    endproperty
    a_wr_flag: assert property (p_wr_flag)
        else $error("write started with no room");
    property p_wr_data;
        $fell(wr_n) |-> host_data_oe [*4];
    endproperty
    a_wr_data: assert property (p_wr_data)
        else $error("write byte not held on pins");
    property p_rd_width;
        $fell(rd_n) |-> (!rd_n) [*4];
    endproperty
    a_rd_width: assert property (p_rd_width)
        else $error("read strobe low too short");
    property p_wake_shape;
        $fell(send_now_wake_n) |-> (!send_now_wake_n) [*4]
            ##1 send_now_wake_n [*4];
    endproperty
    a_wake_shape: assert property (p_wake_shape)
        else $error("wake pulse badly shaped");
    c_read: cover property ($rose(rd_n));
    c_write: cover property ($rose(wr_n));
    c_wake: cover property ($rose(send_now_wake_n));
endmodule : abfp_assertions

// ==== verif/async_byte_fifo_port_bench.sv ====
// bench joining device and host ends of the byte fifo port
// assumes the logic/ files are compiled first
`timescale 1ns/10ps
module async_byte_fifo_port_bench;
    import abfp_pkg::*;
    logic mclk = 0, rst = 1, flt_ff = 0;
    logic fifo_mode_en = 1, usb_active_power_n = 0, remote_wake_en = 1;
    logic rx_push = 0, tx_pop = 0, rd_req = 0, wr_req = 0, wake_req = 0;
    abfp_byte_t rx_push_data = 8'h00, wr_data = 8'h00;
    abfp_byte_t tx_pop_data, rd_data, last_rd;
    logic rx_full, tx_empty, send_now_pulse, resume_req_pulse;
    logic busy, rd_valid;
    int errors = 0, compares = 0, cyc = 0, sn_cnt = 0, rs_cnt = 0;
    abfp_if pins ();
    always #12.5 mclk = ~mclk;
    // released bus flips each cycle so stale data cannot pass
    assign pins.data_in = pins.dev_data_oe ? pins.dev_data_out :
        pins.host_data_oe ? pins.host_data_out : {8{flt_ff}};
    assign pins.rx_data_waiting_n = pins.rx_data_waiting_n_oe ?
        pins.rx_data_waiting_n_out : 1'b1;
    assign pins.tx_room_available_n = pins.tx_room_available_n_oe ?
        pins.tx_room_available_n_out : 1'b1;
    abfp_device abfp_device_inst (.mclk, .rst, .pins, .fifo_mode_en,
        .usb_active_power_n, .remote_wake_en, .rx_push, .rx_push_data,
        .rx_full, .tx_pop, .tx_pop_data, .tx_empty, .send_now_pulse,
        .resume_req_pulse);
    abfp_host abfp_host_inst (.mclk, .rst, .pins, .rd_req, .wr_req,
        .wr_data, .wake_req, .busy, .rd_valid, .rd_data);
    abfp_assertions abfp_assertions_inst (.mclk, .rst, .rd_n(pins.rd_n),
        .wr_n(pins.wr_n), .send_now_wake_n(pins.send_now_wake_n),
        .dev_data_oe(pins.dev_data_oe), .host_data_oe(pins.host_data_oe),
        .rx_data_waiting_n(pins.rx_data_waiting_n),
        .tx_room_available_n(pins.tx_room_available_n),
        .rx_data_waiting_n_oe(pins.rx_data_waiting_n_oe),
        .tx_room_available_n_oe(pins.tx_room_available_n_oe));
    task automatic wrap_up();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        flt_ff <= ~flt_ff;
        if (send_now_pulse === 1'b1) sn_cnt <= sn_cnt + 1;
        if (resume_req_pulse === 1'b1) rs_cnt <= rs_cnt + 1;
        if (rd_valid === 1'b1) last_rd <= rd_data;
        if (cyc == 2000) begin
            errors++;
            wrap_up();
        end
    end
    task automatic check(string what, abfp_byte_t exp, abfp_byte_t got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask : check
    task automatic go(ref logic req);
        @(negedge mclk) req = 1;
        @(negedge mclk) req = 0;
        repeat (60) @(negedge mclk) if (busy === 1'b0) break;
    endtask : go
    task automatic push(abfp_byte_t b);
        rx_push_data = b;
        rx_push = 1;
        @(negedge mclk) rx_push = 0;
        // flag reaches the host through its two-stage sync
        repeat (4) @(negedge mclk);
    endtask : push
    task automatic t_write();
        abfp_byte_t v [2] = '{8'h5A, 8'hC3};
        foreach (v[i]) begin
            wr_data = v[i];
            go(wr_req);
        end
        check("room", 8'h00, {7'h00, pins.tx_room_available_n});
        foreach (v[i]) begin
            check("tx byte", v[i], tx_pop_data);
            tx_pop = 1;
            @(negedge mclk) tx_pop = 0;
        end
        check("tx empty", 8'h01, {7'h00, tx_empty});
    endtask : t_write
    task automatic t_read();
        abfp_byte_t v [2] = '{8'h3C, 8'h81};
        foreach (v[i]) push(v[i]);
        check("waiting", 8'h00, {7'h00, pins.rx_data_waiting_n});
        foreach (v[i]) begin
            go(rd_req);
            check("rd byte", v[i], last_rd);
            repeat (4) @(negedge mclk);
        end
        check("drained", 8'h01, {7'h00, pins.rx_data_waiting_n});
    endtask : t_read
    task automatic t_wake();
        int s = sn_cnt;
        int r = rs_cnt;
        go(wake_req);
        check("send now", 8'h01, 8'(sn_cnt - s));
        usb_active_power_n = 1;
        go(wake_req);
        check("resume", 8'h01, 8'(rs_cnt - r));
        remote_wake_en = 0;
        go(wake_req);
        check("no resume", 8'h01, 8'(rs_cnt - r));
        check("send once", 8'h01, 8'(sn_cnt - s));
        usb_active_power_n = 0;
    endtask : t_wake
    task automatic t_mode_off();
        fifo_mode_en = 0;
        push(8'hE7);
        check("off flag", 8'h01, {7'h00, pins.rx_data_waiting_n});
        fifo_mode_en = 1;
        repeat (4) @(negedge mclk);
        check("on flag", 8'h00, {7'h00, pins.rx_data_waiting_n});
        go(rd_req);
        check("on byte", 8'hE7, last_rd);
    endtask : t_mode_off
    task automatic t_full();
        // seventeenth push must be dropped by the full receive fifo
        for (int i = 0; i < 17; i++) push(8'(8'h10 + i));
        check("rx full", 8'h01, {7'h00, rx_full});
        for (int i = 0; i < 16; i++) begin
            go(rd_req);
            check("full rd", 8'(8'h10 + i), last_rd);
        end
        check("rx empty", 8'h01, {7'h00, pins.rx_data_waiting_n});
        for (int i = 0; i < 16; i++) begin
            wr_data = 8'(8'h20 + i);
            go(wr_req);
        end
        check("no room", 8'h01, {7'h00, pins.tx_room_available_n});
        wr_data = 8'hFF;
        go(wr_req);
        for (int i = 0; i < 16; i++) begin
            check("full tx", 8'(8'h20 + i), tx_pop_data);
            tx_pop = 1;
            @(negedge mclk) tx_pop = 0;
        end
        check("tx drained", 8'h01, {7'h00, tx_empty});
    endtask : t_full
    initial begin
        repeat (16) @(negedge mclk);
        check("rst rx", 8'h01, {7'h00, pins.rx_data_waiting_n});
        check("rst tx", 8'h01, {7'h00, pins.tx_room_available_n});
        rst = 0;
        repeat (3) @(negedge mclk);
        t_write();
        t_read();
        t_wake();
        t_mode_off();
        t_full();
        wrap_up();
    end
endmodule : async_byte_fifo_port_bench
